// File: bench/plcc_link_asserts.sv
// Checker for the link capability and control registers of one port.
// Assumes it is bound to every instance of the port module.
`timescale 1ns/1ps
module plcc_link_asserts
    import plcc_pkg::*;
#(
    parameter bit          IS_UPSTREAM   = 1'b1,
    parameter bit          WIDE_UPSTREAM = 1'b0,
    parameter logic [12:0] NORM_FTS      = 13'h0080,
    parameter logic [12:0] NORM_TS1      = 13'h0010
) (
    // Clock, reset and bus
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // Link side
    input wire plcc_ctrl_s  ctrlOut,
    input wire logic [12:0] ftsCount,
    input wire logic [12:0] ts1Count,
    input wire logic        clkNeeded,
    input wire logic        clkReqOut,
    input wire logic        clkReqOeN
);
    localparam logic [5:0] WID =
        (IS_UPSTREAM && WIDE_UPSTREAM) ? 6'h04 : 6'h01;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence acc(w, a);
        hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
    endsequence
    sequence wrCtl;
        acc(1'b1, 8'hd0) ##1 hready;
    endsequence
    AST_CAP_ROLE: assert property (
        acc(1'b0, 8'hcc) |=> hrdata[9:4] == WID && hrdata[20] == !IS_UPSTREAM)
        else $error("role fields of capability word wrong");
    AST_CAP_CLKPM_DN: assert property (
        acc(1'b0, 8'hcc) |=> IS_UPSTREAM || !hrdata[18])
        else $error("downstream clock pm capability set");
    AST_CTL_RSVD: assert property (
        acc(1'b0, 8'hd0) |=> (hrdata & 32'hffff_f02c) == 32'h0)
        else $error("fixed control bits read nonzero");
    AST_CTL_UP_RO: assert property (
        IS_UPSTREAM |-> !ctrlOut.linkDisable && !ctrlOut.bwMgmtIntEn
        && !ctrlOut.autoBwIntEn) else $error("upstream fixed control set");
    AST_RETRAIN: assert property (
        acc(1'b1, 8'hd0) ##1 (hready && hwdata[5])
        |=> ctrlOut.retrainPulse == !IS_UPSTREAM) else $error("retrain wrong");
    AST_RETRAIN_ONE: assert property (
        ctrlOut.retrainPulse |=> !ctrlOut.retrainPulse)
        else $error("retrain pulse too long");
    AST_RX_L0S: assert property (
        ctrlOut.rxL0sAllowed) else $error("receiver L0s blocked");
    AST_ASPM_WR: assert property (
        acc(1'b1, 8'hd0) ##1 hready |=> {ctrlOut.aspmL1En, ctrlOut.aspmL0sEn}
        == $past(hwdata[1:0])) else $error("power state enables wrong");
    AST_EXT_SYNC: assert property (
        ftsCount == (ctrlOut.extSync ? 13'h1000 : NORM_FTS)
        && ts1Count == (ctrlOut.extSync ? 13'h0400 : NORM_TS1))
        else $error("ordered set counts wrong");
    AST_CLKREQ: assert property (
        clkNeeded || !IS_UPSTREAM |=> !clkReqOeN && !clkReqOut)
        else $error("clock request pin released");
    AST_LINK_DIS: assert property (
        wrCtl |=> ctrlOut.linkDisable == (!IS_UPSTREAM && $past(hwdata[4])))
        else $error("link disable wrong");
    AST_CLKPM_OFF: assert property (
        wrCtl ##0 !hwdata[8] |=> !clkReqOeN && !clkReqOut)
        else $error("clock request released with clock pm off");
endmodule
bind plcc_port_link_cap_ctrl plcc_link_asserts #(
    .IS_UPSTREAM(IS_UPSTREAM), .WIDE_UPSTREAM(WIDE_UPSTREAM),
    .NORM_FTS(NORM_FTS), .NORM_TS1(NORM_TS1)
) u_chk (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .ctrlOut, .ftsCount, .ts1Count, .clkNeeded, .clkReqOut,
    .clkReqOeN);

// File: bench/plcc_link_partner.sv
// Link partner model: asks the port for the reference clock on clkNeeded and resolves the CLKREQ# wire.
// Assumes the port drives the pin open drain, enable low, with a pull-up.
`timescale 1ns/1ps
module plcc_link_partner
    import plcc_pkg::*;
(
    // Port side of the pin
    input  wire logic core_clk,
    input  wire logic clkReqOut,
    input  wire logic clkReqOeN,
    // Clock demand and resolved wire level
    output logic      clkNeeded,
    output wire logic clkReqWire
);
    // A released pin reads the pull-up level, never a stale driven value.
    assign clkReqWire = clkReqOeN ? 1'b1 : clkReqOut;
    initial clkNeeded = 1'b0;
    task automatic needClk(input logic v);
        @(posedge core_clk);
        clkNeeded <= v;
    endtask
endmodule

// File: bench/tb.sv
// Bench for one upstream port and one downstream port on a shared bus.
// Assumes slaves that may stretch a phase; the master waits on hready.
`timescale 1ns/1ps
module tb
    import plcc_pkg::*;
;
    logic          core_clk;
    logic          rst     = 1'b1;
    logic          sel     = 1'b0;
    logic          hwrite  = 1'b0;
    logic [1:0]    htrans  = 2'h0;
    logic [31:0]   haddr   = 32'h0;
    logic [31:0]   hwdata  = 32'h0;
    logic [31:0]   rdat;
    plcc_capload_s capLoad = '0;
    int            failures = 0;
    int            checked  = 0;
    wire [1:0]     hro, hrs, cro, coe, need, pin;
    wire [31:0]    hrd [2];
    wire plcc_ctrl_s ctl [2];
    wire [12:0]    fts [2];
    wire [12:0]    ts1 [2];
    wire           hready = hro[sel];
    for (genvar g = 0; g < 2; g++) begin : port
        plcc_port_link_cap_ctrl #(.IS_UPSTREAM(g == 0),
            .PORT_INDEX(g == 0 ? 0 : 5)) dut (.core_clk(core_clk), .rst(rst),
            .hsel(sel == g), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
            .hsize(3'h2), .hwdata(hwdata), .hready(hready),
            .hreadyout(hro[g]), .hrdata(hrd[g]), .hresp(hrs[g]),
            .capLoad(capLoad), .ctrlOut(ctl[g]), .ftsCount(fts[g]),
            .ts1Count(ts1[g]), .clkNeeded(need[g]), .clkReqIn(pin[g]),
            .clkReqOut(cro[g]), .clkReqOeN(coe[g]));
        plcc_link_partner lp (.core_clk(core_clk), .clkReqOut(cro[g]),
            .clkReqOeN(coe[g]), .clkNeeded(need[g]), .clkReqWire(pin[g]));
    end
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic xfer(input logic w, input int s, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        sel <= s[0];
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrd[s];
    endtask
    task automatic chk(input logic [31:0] act, exp, input string m);
        checked++;
        if (act !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h want %h",
                     $time, m, act, exp);
        end
    endtask
    task automatic t_reset();
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        xfer(0, 0, 8'hcc, 0, rdat);
        chk(rdat, 32'h0004_3012, "up");
        xfer(0, 1, 8'hcc, 0, rdat);
        chk(rdat, 32'h0510_3012, "dn cap");
        for (int p = 0; p < 2; p++) begin
            xfer(0, p, 8'hd0, 0, rdat);
            chk(rdat, 32'h0, "ctl");
            chk({22'h0, ctl[p]}, 32'h80, "ctl out");
            chk({ts1[p], fts[p]}, {13'h0010, 13'h0080}, "counts");
        end
        $display("test reset done");
    endtask
    task automatic t_ro();
        xfer(1, 0, 8'hcc, 32'hffff_ffff, rdat);
        xfer(1, 0, 8'h40, 32'hffff_ffff, rdat);
        xfer(0, 0, 8'hcc, 0, rdat);
        chk(rdat, 32'h0004_3012, "cap kept");
        xfer(0, 0, 8'h40, 0, rdat);
        chk(rdat, 32'h0, "unmapped");
        chk(hrs, 2'b00, "resp");
        $display("test read-only done");
    endtask
    task automatic t_aspm();
        for (int c = 0; c < 4; c++) begin
            xfer(1, 0, 8'hd0, c, rdat);
            #1;
            chk({ctl[0].aspmL1En, ctl[0].aspmL0sEn}, c, "enable");
            chk(ctl[0].rxL0sAllowed, 1, "rx L0s");
            xfer(0, 0, 8'hd0, 0, rdat);
            chk(rdat, c, "aspm read");
        end
        $display("test power states done");
    endtask
    task automatic t_ctrl();
        for (int p = 0; p < 2; p++) begin
            xfer(1, p, 8'hd0, 32'hffff_ffff, rdat);
            #1;
            chk(ctl[p].retrainPulse, p, "retrain");
            chk(ctl[p].linkDisable, p, "disable");
            chk({22'h0, ctl[p]}, p ? 32'h3ff : 32'h39c, "all");
            chk({ts1[p], fts[p]}, {13'h0400, 13'h1000}, "ext");
            @(posedge core_clk);
            #1;
            chk(ctl[p].retrainPulse, 0, "pulse end");
            xfer(0, p, 8'hd0, 0, rdat);
            chk(rdat, p ? 32'hed3 : 32'h3c3, "mask");
            xfer(1, p, 8'hd0, 0, rdat);
            #1;
            chk({ts1[p], fts[p]}, {13'h0010, 13'h0080}, "norm");
        end
        $display("test control done");
    endtask
    task automatic t_clk();
        xfer(1, 0, 8'hd0, 32'h100, rdat);
        xfer(1, 1, 8'hd0, 32'h100, rdat);
        @(posedge core_clk);
        #1;
        chk(pin, 2'b01, "released");
        port[0].lp.needClk(1'b1);
        @(posedge core_clk);
        #1;
        chk(pin, 2'b00, "held low");
        port[0].lp.needClk(1'b0);
        $display("test clock request done");
    endtask
    task automatic t_load();
        @(posedge core_clk);
        capLoad <= {1'b1, 32'h023b_dff1};
        @(posedge core_clk);
        capLoad <= '0;
        xfer(0, 0, 8'hcc, 0, rdat);
        chk(rdat, 32'h022b_dc11, "loaded");
        $display("test load done");
    endtask
    task automatic stop_test();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // The whole run needs about 100 cycles; this bound of 2000 cycles is generous.
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    initial begin
        t_reset();
        t_ro();
        t_aspm();
        t_ctrl();
        t_clk();
        t_load();
        t_reset();
        stop_test();
    end
endmodule

// File: src/plcc_defs.svh
// Offsets, field positions, reset values and counts of the link block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PLCC_DEFS_SVH
`define PLCC_DEFS_SVH

`define PLCC_OFS_LINK_CAP      8'hcc
`define PLCC_OFS_LINK_CTRL     8'hd0

`define PLCC_CAP_SPEED_LSB     0
`define PLCC_CAP_SPEED_MSB     3
`define PLCC_CAP_WIDTH_LSB     4
`define PLCC_CAP_WIDTH_MSB     9
`define PLCC_CAP_ASPM_LSB      10
`define PLCC_CAP_ASPM_MSB      11
`define PLCC_CAP_L0S_LSB       12
`define PLCC_CAP_L0S_MSB       14
`define PLCC_CAP_L1_LSB        15
`define PLCC_CAP_L1_MSB        17
`define PLCC_CAP_CLKPM_BIT     18
`define PLCC_CAP_SDOWN_BIT     19
`define PLCC_CAP_DLLREP_BIT    20
`define PLCC_CAP_BWNOTE_BIT    21
`define PLCC_CAP_PORT_LSB      24
`define PLCC_CAP_PORT_MSB      31

`define PLCC_RST_SPEED         4'h2
`define PLCC_SPEED_2G5         4'h1
`define PLCC_SPEED_5G0         4'h2
`define PLCC_RST_WIDTH_X4      6'h04
`define PLCC_RST_WIDTH_X1      6'h01
`define PLCC_RST_ASPM_SUP      2'h0
`define PLCC_RST_L0S_LAT       3'h3
`define PLCC_RST_L1_LAT        3'h0
`define PLCC_RST_SDOWN         1'h0
`define PLCC_RST_BWNOTE        1'h0

`define PLCC_CTL_ASPM_LSB      0
`define PLCC_CTL_ASPM_MSB      1
`define PLCC_CTL_RDCMPL_BIT    3
`define PLCC_CTL_DIS_BIT       4
`define PLCC_CTL_RETRAIN_BIT   5
`define PLCC_CTL_CCC_BIT       6
`define PLCC_CTL_EXTSYNC_BIT   7
`define PLCC_CTL_CLKPM_BIT     8
`define PLCC_CTL_HWALO_BIT     9
`define PLCC_CTL_BWMIE_BIT     10
`define PLCC_CTL_ABWIE_BIT     11

`define PLCC_EXT_FTS_COUNT     13'h1000
`define PLCC_EXT_TS1_COUNT     13'h0400

`endif

// File: src/plcc_pkg.sv
// Types shared by the link capability and control block.
// Assumes the defs header sits beside it on the include path.
package plcc_pkg;
    `include "plcc_defs.svh"

    typedef enum logic [1:0] {
        PLCC_ASPM_OFF  = 2'b00,
        PLCC_ASPM_L0S  = 2'b01,
        PLCC_ASPM_L1   = 2'b10,
        PLCC_ASPM_BOTH = 2'b11
    } plcc_aspm_e;

    typedef struct packed {
        logic aspmL0sEn;
        logic aspmL1En;
        logic rxL0sAllowed;
        logic linkDisable;
        logic retrainPulse;
        logic commonClk;
        logic extSync;
        logic hwAutoLaneCountOff;
        logic bwMgmtIntEn;
        logic autoBwIntEn;
    } plcc_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } plcc_capload_s;
endpackage

// File: src/plcc_port_link_cap_ctrl.sv
// Link capability and link control registers of one switch port.
// Assumes an AHB-Lite master on core_clk; hsel and hready let it share the bus with other slaves.
`timescale 1ns/1ps
`include "plcc_defs.svh"

module plcc_port_link_cap_ctrl
    import plcc_pkg::*;
#(
    parameter bit          IS_UPSTREAM   = 1'b1,
    parameter bit          WIDE_UPSTREAM = 1'b0,
    parameter int unsigned PORT_INDEX    = 0,
    parameter logic [12:0] NORM_FTS      = 13'h0080,
    parameter logic [12:0] NORM_TS1      = 13'h0010
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    // Serial management or memory autoload of capability defaults
    input  wire plcc_capload_s capLoad,
    // Link controls toward the training logic
    output plcc_ctrl_s         ctrlOut,
    output logic [12:0]        ftsCount,
    output logic [12:0]        ts1Count,
    // Clock request pin, open drain, enable low while driving
    input  wire logic          clkNeeded,
    input  wire logic          clkReqIn,
    output logic               clkReqOut,
    output logic               clkReqOeN
);

    if (PORT_INDEX > 5) begin : g_badPortIndex
        $error("PORT_INDEX must be 0 to 5");
    end

    if (WIDE_UPSTREAM && !IS_UPSTREAM) begin : g_badWideRole
        $error("WIDE_UPSTREAM applies to the upstream port only");
    end

    // A zero count leaves the partner nothing to regain lock on.
    if (NORM_FTS == 13'h0000 || NORM_TS1 == 13'h0000) begin : g_badNormZero
        $error("NORM_FTS and NORM_TS1 must be nonzero");
    end

    // Extended sync must never shorten an exit sequence.
    if (NORM_FTS > `PLCC_EXT_FTS_COUNT) begin : g_badNormFts
        $error("NORM_FTS must not exceed the extended count");
    end

    if (NORM_TS1 > `PLCC_EXT_TS1_COUNT) begin : g_badNormTs1
        $error("NORM_TS1 must not exceed the extended count");
    end

    // Reset value of the capability word for this port's role.
    function automatic logic [31:0] capResetValue();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`PLCC_CAP_SPEED_MSB:`PLCC_CAP_SPEED_LSB] =
            `PLCC_RST_SPEED;
        v[`PLCC_CAP_WIDTH_MSB:`PLCC_CAP_WIDTH_LSB] =
            (IS_UPSTREAM && WIDE_UPSTREAM) ? `PLCC_RST_WIDTH_X4
                                           : `PLCC_RST_WIDTH_X1;
        v[`PLCC_CAP_ASPM_MSB:`PLCC_CAP_ASPM_LSB] =
            `PLCC_RST_ASPM_SUP;
        v[`PLCC_CAP_L0S_MSB:`PLCC_CAP_L0S_LSB] = `PLCC_RST_L0S_LAT;
        v[`PLCC_CAP_L1_MSB:`PLCC_CAP_L1_LSB] = `PLCC_RST_L1_LAT;
        v[`PLCC_CAP_CLKPM_BIT] = IS_UPSTREAM;
        v[`PLCC_CAP_SDOWN_BIT] = `PLCC_RST_SDOWN;
        v[`PLCC_CAP_DLLREP_BIT] = !IS_UPSTREAM;
        v[`PLCC_CAP_BWNOTE_BIT] = `PLCC_RST_BWNOTE;
        v[`PLCC_CAP_PORT_MSB:`PLCC_CAP_PORT_LSB] = 8'(PORT_INDEX);
        return v;
    endfunction

    // Fields the loader may replace; width and role bits stay fixed.
    function automatic logic [31:0] capLoadMask();
        logic [31:0] m;
        m = 32'h0000_0000;
        m[`PLCC_CAP_SPEED_MSB:`PLCC_CAP_SPEED_LSB] = 4'hf;
        m[`PLCC_CAP_ASPM_MSB:`PLCC_CAP_ASPM_LSB] = 2'h3;
        m[`PLCC_CAP_L0S_MSB:`PLCC_CAP_L0S_LSB] = 3'h7;
        m[`PLCC_CAP_L1_MSB:`PLCC_CAP_L1_LSB] = 3'h7;
        m[`PLCC_CAP_CLKPM_BIT] = IS_UPSTREAM;
        m[`PLCC_CAP_SDOWN_BIT] = 1'b1;
        m[`PLCC_CAP_BWNOTE_BIT] = 1'b1;
        m[`PLCC_CAP_PORT_MSB:`PLCC_CAP_PORT_LSB] = 8'hff;
        return m;
    endfunction

    // Bits of the control word that software may set on this port.
    function automatic logic [15:0] ctrlWriteMask();
        logic [15:0] m;
        m = 16'h0000;
        m[`PLCC_CTL_ASPM_MSB:`PLCC_CTL_ASPM_LSB] = 2'h3;
        m[`PLCC_CTL_DIS_BIT] = !IS_UPSTREAM;
        m[`PLCC_CTL_CCC_BIT] = 1'b1;
        m[`PLCC_CTL_EXTSYNC_BIT] = 1'b1;
        m[`PLCC_CTL_CLKPM_BIT] = IS_UPSTREAM;
        m[`PLCC_CTL_HWALO_BIT] = 1'b1;
        m[`PLCC_CTL_BWMIE_BIT] = !IS_UPSTREAM;
        m[`PLCC_CTL_ABWIE_BIT] = !IS_UPSTREAM;
        return m;
    endfunction

    // Only the low address byte is decoded, so registers alias upward.
    function automatic logic isCapAddr(input logic [7:0] a);
        return a == `PLCC_OFS_LINK_CAP;
    endfunction

    function automatic logic isCtrlAddr(input logic [7:0] a);
        return a == `PLCC_OFS_LINK_CTRL;
    endfunction

    localparam logic [31:0] CAP_RST  = capResetValue();
    localparam logic [31:0] CAP_MASK = capLoadMask();
    localparam logic [15:0] CTL_MASK = ctrlWriteMask();

    logic [31:0] capReg_r;
    logic [15:0] ctrlReg_r;
    logic [15:0] ctrlReg_nxt;
    logic        wrPend_r;
    logic [7:0]  wrAddr_r;
    logic        retrainReq;
    logic        addrPhase;
    logic [31:0] rdData_nxt;

    assign addrPhase = hsel && hready && htrans[1];

    // Write data arrives one cycle after its address phase.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else if (hready) begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= haddr[7:0];
        end
    end

    always_comb begin
        ctrlReg_nxt = ctrlReg_r;
        retrainReq  = 1'b0;
        if (wrPend_r && isCtrlAddr(wrAddr_r)) begin
            ctrlReg_nxt = hwdata[15:0] & CTL_MASK;
            // Retrain is a strobe and never stored.
            retrainReq  = !IS_UPSTREAM && hwdata[`PLCC_CTL_RETRAIN_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            capReg_r <= CAP_RST;
        end else if (capLoad.valid) begin
            capReg_r <= (capReg_r & ~CAP_MASK) |
                        (capLoad.data & CAP_MASK);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlReg_r <= 16'h0000;
        end else begin
            ctrlReg_r <= ctrlReg_nxt;
        end
    end

    // Reads use the post-write control value so a read right behind a
    // write sees the new data without a wait state.
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (isCapAddr(haddr[7:0])) begin
            rdData_nxt = capReg_r;
        end else if (isCtrlAddr(haddr[7:0])) begin
            rdData_nxt = {16'h0000, ctrlReg_nxt};
        end else begin
            rdData_nxt = 32'h0000_0000;
        end
    end

    // Bit 3 and bit 5 are never stored, so both read 0.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdData_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlOut <= '{rxL0sAllowed: 1'b1, default: 1'b0};
        end else begin
            ctrlOut.aspmL0sEn  <= ctrlReg_nxt[`PLCC_CTL_ASPM_LSB];
            ctrlOut.aspmL1En   <= ctrlReg_nxt[`PLCC_CTL_ASPM_MSB];
            ctrlOut.rxL0sAllowed <= 1'b1;
            ctrlOut.linkDisable <= ctrlReg_nxt[`PLCC_CTL_DIS_BIT];
            ctrlOut.retrainPulse <= retrainReq;
            ctrlOut.commonClk  <= ctrlReg_nxt[`PLCC_CTL_CCC_BIT];
            ctrlOut.extSync    <= ctrlReg_nxt[`PLCC_CTL_EXTSYNC_BIT];
            ctrlOut.hwAutoLaneCountOff <= ctrlReg_nxt[`PLCC_CTL_HWALO_BIT];
            ctrlOut.bwMgmtIntEn <= ctrlReg_nxt[`PLCC_CTL_BWMIE_BIT];
            ctrlOut.autoBwIntEn <= ctrlReg_nxt[`PLCC_CTL_ABWIE_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ftsCount <= NORM_FTS;
        end else if (ctrlReg_nxt[`PLCC_CTL_EXTSYNC_BIT]) begin
            ftsCount <= `PLCC_EXT_FTS_COUNT;
        end else begin
            ftsCount <= NORM_FTS;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ts1Count <= NORM_TS1;
        end else if (ctrlReg_nxt[`PLCC_CTL_EXTSYNC_BIT]) begin
            ts1Count <= `PLCC_EXT_TS1_COUNT;
        end else begin
            ts1Count <= NORM_TS1;
        end
    end

    // The pin is only ever pulled low; releasing it lets the partner or
    // pull-up decide, which is why clkReqIn is left for the link logic.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clkReqOut <= 1'b0;
            clkReqOeN <= 1'b0;
        end else begin
            clkReqOut <= 1'b0;
            clkReqOeN <= ctrlReg_nxt[`PLCC_CTL_CLKPM_BIT] &&
                         !clkNeeded;
        end
    end

endmodule
